/* rtl/voltage_reference_control.sv */
// apb register bank controlling a fixed voltage reference and temp indicator
// assumes apb master on sys_clk, analog settle flag synchronous to sys_clk
//
// Behaviour
// R1 - enable bit powers reference up or down
// R2 - ready set only after analog settled
// R3 - ready reads zero when unstable or disabled
// R4 - high-voltage variant reads ready always one
// R5 - temp indicator enable bit switches circuit
// R6 - range bit selects high or low
// R7 - comparator/dac gain field decode
// R8 - adc gain field decode
// R9 - two gain fields independent
// R10 - writes to ready bit ignored
//
// Chosen here: the register offsets and the APB register port.
`include "vref_ctrl_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module voltage_reference_control #(
    parameter bit HighVoltVariant = 1'b0 // selects variant whose ready flag is fixed one
) (
    // clock, enable, reset
    input wire logic sys_clk,
    input wire logic clkEn,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog side
    input wire logic refSettled,
    output logic referenceEnable,
    output logic tempIndicatorEnable,
    output logic tempRangeSelect,
    output logic [1:0] cmpDacGainSelect,
    output logic [1:0] adcGainSelect,
    output logic [2:0] cmpDacGain,
    output logic [2:0] adcGain
);
    // ==========================================
    // elaboration check
    initial begin
        if (`VREF_READY_BIT != 6) begin
            $error("ready bit must sit at position 6");
        end
    end

    // ==========================================
    // control state
    logic [7:0] ctrl_r; // writable bits; ready position kept zero
    logic [7:0] ctrl_nxt;
    logic ready_r; // stabilisation flag
    logic ready_nxt;
    logic [31:0] rdata_r; // read data register
    logic [31:0] rdata_nxt;
    logic slvErr_r; // error answer register
    logic slvErr_nxt;
    logic access; // access phase
    logic hit; // address decodes to control register
    logic [7:0] readView; // register as software reads it

    assign access = psel && penable && clkEn;
    assign hit = (paddr == `VREF_CTRL_OFFSET);

    // ready flag value as read
    always_comb begin
        readView = ctrl_r;
        readView[`VREF_READY_BIT] = HighVoltVariant ? 1'b1 : ready_r; // R4
    end

    // next-state computation
    always_comb begin
        ctrl_nxt = ctrl_r;
        ready_nxt = ready_r;
        rdata_nxt = rdata_r;
        slvErr_nxt = slvErr_r;
        if (clkEn) begin
            // ready only when enabled and settled, else zero
            ready_nxt = ctrl_r[`VREF_ENABLE_BIT] && refSettled; // R2 R3
            if (psel && !penable) begin
                // setup: prepare answer
                slvErr_nxt = !hit;
                rdata_nxt = hit ? {24'h000000, readView} : 32'h00000000;
                if (hit && pwrite) begin
                    rdata_nxt = 32'h00000000;
                end
            end
        end
        if (access && hit && pwrite) begin
            ctrl_nxt = pwdata[7:0];
            ctrl_nxt[`VREF_READY_BIT] = 1'b0; // R10
            ready_nxt = 1'b0; // R3
        end
    end

    // registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_r <= `VREF_CTRL_RESET;
            ready_r <= 1'b0;
            rdata_r <= 32'h00000000;
            slvErr_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            ready_r <= ready_nxt;
            rdata_r <= rdata_nxt;
            slvErr_r <= slvErr_nxt;
        end
    end

    // ==========================================
    // outputs
    assign pready = 1'b1;
    assign prdata = rdata_r;
    assign pslverr = access && slvErr_r;
    assign referenceEnable = ctrl_r[`VREF_ENABLE_BIT]; // R1
    assign tempIndicatorEnable = ctrl_r[`VREF_TEMP_EN_BIT]; // R5
    assign tempRangeSelect = ctrl_r[`VREF_TEMP_RNG_BIT]; // R6
    assign cmpDacGainSelect = ctrl_r[`VREF_CMP_GAIN_LSB +: 2]; // R9
    assign adcGainSelect = ctrl_r[`VREF_ADC_GAIN_LSB +: 2]; // R9

    // gain decode to one-hot {4x,2x,1x}; zero means buffer off
    function automatic logic [2:0] decodeGain(input logic [1:0] code);
        case (vref_ctrl_pkg::gain_code_t'(code))
            vref_ctrl_pkg::GAIN_X4: decodeGain = 3'h4;
            vref_ctrl_pkg::GAIN_X2: decodeGain = 3'h2;
            vref_ctrl_pkg::GAIN_X1: decodeGain = 3'h1;
            default: decodeGain = 3'h0;
        endcase
    endfunction
    assign cmpDacGain = decodeGain(cmpDacGainSelect); // R7
    assign adcGain = decodeGain(adcGainSelect); // R8

    // ==========================================
    // assertions
    chk_ready_needs_enable: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
        (!HighVoltVariant && !$past(referenceEnable)) |-> !readView[6])
        else $error("ready seen while reference disabled");
    chk_ready_follows_settle: assert property (@(posedge sys_clk) disable iff (!rst_n) // R2
        (clkEn && referenceEnable && refSettled && !(access && pwrite)) |=> ready_r)
        else $error("ready not raised after settle");
    chk_ready_drop: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
        (clkEn && !refSettled) |=> !ready_r)
        else $error("ready stayed while unsettled");
    chk_variant_ready: assert property (@(posedge sys_clk) disable iff (!rst_n) // R4
        HighVoltVariant |-> readView[6])
        else $error("variant ready not one");
    chk_enable_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // R1
        (access && hit && pwrite) |=> referenceEnable == $past(pwdata[7]))
        else $error("enable not written");
    chk_temp_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // R5
        (access && hit && pwrite) |=> {tempIndicatorEnable, tempRangeSelect}
            == $past(pwdata[5:4])) // R6
        else $error("temp bits not written");
    chk_cmp_decode: assert property (@(posedge sys_clk) disable iff (!rst_n) // R7
        (cmpDacGainSelect == 2'h3) |-> cmpDacGain == 3'h4)
        else $error("cmp gain decode wrong");
    chk_adc_decode: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
        (adcGainSelect == 2'h1) |-> adcGain == 3'h1)
        else $error("adc gain decode wrong");
    chk_gain_independent: assert property (@(posedge sys_clk) disable iff (!rst_n) // R9
        (access && hit && pwrite) |=> adcGainSelect == $past(pwdata[1:0]))
        else $error("adc gain not independent");
    chk_ready_bit_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
        (access && hit && pwrite && pwdata[6] && !HighVoltVariant) |=> !readView[6])
        else $error("ready bit took write");
    cov_enable: cover property (@(posedge sys_clk) access && hit && pwrite && pwdata[7]);
    cov_ready: cover property (@(posedge sys_clk) !ready_r ##1 ready_r);
    cov_read: cover property (@(posedge sys_clk) access && hit && !pwrite);
    cov_bad: cover property (@(posedge sys_clk) access && !hit);
    cov_freeze: cover property (@(posedge sys_clk) !clkEn && psel && penable && pwrite);

    // ==========================================
    // clock enable and refused accesses
    // a low clock enable must hold every bit of state, bus traffic included,
    // so a stalled system clock domain never sees a half-applied write
    // frozen cycle leaves register and flag untouched
    chk_clken_freeze: assert property (@(posedge sys_clk) disable iff (!rst_n) // R1
        !clkEn |=> ($stable(ctrl_r) && $stable(ready_r)))
        else $error("state moved while clock enable low");
    // a write to an unmapped offset must not reach the register
    chk_refused_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // R1
        (access && !hit && pwrite) |=> $stable(ctrl_r))
        else $error("unmapped write changed register");
    // any accepted write restarts the settle check for one cycle
    chk_ready_cleared_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
        (access && hit && pwrite) |=> !ready_r)
        else $error("ready survived a register write");

    // ==========================================
    // remaining gain codes, both buffers
    // every code is pinned so a swapped pair of decode arms cannot hide
    // comparator/dac buffer at 2x
    chk_cmp_x2: assert property (@(posedge sys_clk) disable iff (!rst_n) // R7
        (cmpDacGainSelect == 2'h2) |-> cmpDacGain == 3'h2)
        else $error("cmp gain 2x decode wrong");
    // comparator/dac buffer at 1x
    chk_cmp_x1: assert property (@(posedge sys_clk) disable iff (!rst_n) // R7
        (cmpDacGainSelect == 2'h1) |-> cmpDacGain == 3'h1)
        else $error("cmp gain 1x decode wrong");
    // comparator/dac buffer switched off
    chk_cmp_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // R7
        (cmpDacGainSelect == 2'h0) |-> cmpDacGain == 3'h0)
        else $error("cmp buffer not off");
    // adc buffer at 4x
    chk_adc_x4: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
        (adcGainSelect == 2'h3) |-> adcGain == 3'h4)
        else $error("adc gain 4x decode wrong");
    // adc buffer at 2x
    chk_adc_x2: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
        (adcGainSelect == 2'h2) |-> adcGain == 3'h2)
        else $error("adc gain 2x decode wrong");
    // adc buffer switched off
    chk_adc_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
        (adcGainSelect == 2'h0) |-> adcGain == 3'h0)
        else $error("adc buffer not off");
    // comparator/dac field takes its own slice of the write
    chk_cmp_independent: assert property (@(posedge sys_clk) disable iff (!rst_n) // R9
        (access && hit && pwrite) |=> cmpDacGainSelect == $past(pwdata[3:2]))
        else $error("cmp gain not independent");
endmodule
`default_nettype wire

/* rtl/vref_ctrl_defines.svh */
// constants for the voltage reference control register bank
// assumes inclusion by bare name from the rtl files
`ifndef VREF_CTRL_DEFINES_SVH
`define VREF_CTRL_DEFINES_SVH

// ==========================================
// register map
`define VREF_CTRL_OFFSET 12'h000
`define VREF_CTRL_RESET 8'h00

// ==========================================
// field positions
`define VREF_ENABLE_BIT 7
`define VREF_READY_BIT 6
`define VREF_TEMP_EN_BIT 5
`define VREF_TEMP_RNG_BIT 4
`define VREF_CMP_GAIN_LSB 2
`define VREF_ADC_GAIN_LSB 0

`endif

/* rtl/vref_ctrl_pkg.sv */
// types for the voltage reference control register bank
// assumes nothing of its surroundings
package vref_ctrl_pkg;
    // ==========================================
    // buffer gain code
    typedef enum logic [1:0] {
        GAIN_OFF = 2'h0,
        GAIN_X1 = 2'h1,
        GAIN_X2 = 2'h2,
        GAIN_X4 = 2'h3
    } gain_code_t;
endpackage

/* tb/testbench.sv */
// self-checking bench for the voltage reference control register bank
// assumes the rtl files are compiled first; the bench is the apb master
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ==========================================
    // signals
    logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic refSettled = 1'b0, pready, pslverr, err, referenceEnable, tempIndicatorEnable;
    logic tempRangeSelect;
    logic clkEn = 1'b1; // clock enable, dropped once to check the freeze
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, prdataHv, rd, rdHv;
    logic [1:0] cmpDacGainSelect, adcGainSelect;
    logic [2:0] cmpDacGain, adcGain;
    logic [7:0] d; // last value written
    int miscompares = 0, tests_run = 0, cyc = 0;
    // 20 mhz clock
    always #25 sys_clk = ~sys_clk;
    // standard variant
    voltage_reference_control dut (.sys_clk(sys_clk), .clkEn(clkEn), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .refSettled(refSettled),
        .referenceEnable(referenceEnable), .tempIndicatorEnable(tempIndicatorEnable),
        .tempRangeSelect(tempRangeSelect), .cmpDacGainSelect(cmpDacGainSelect),
        .adcGainSelect(adcGainSelect), .cmpDacGain(cmpDacGain), .adcGain(adcGain));
    // variant with ready fixed high, sharing the bus
    voltage_reference_control #(.HighVoltVariant(1'b1)) dutHv (.sys_clk(sys_clk),
        .clkEn(clkEn), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdataHv), .pready(), .pslverr(),
        .refSettled(refSettled), .referenceEnable(), .tempIndicatorEnable(),
        .tempRangeSelect(), .cmpDacGainSelect(), .adcGainSelect(), .cmpDacGain(), .adcGain());
    // ==========================================
    // helpers
    function automatic logic [2:0] gainOneHot(input logic [1:0] c);
        return (c == 2'h0) ? 3'h0 : 3'h1 << (c - 2'h1);
    endfunction
    function automatic logic [31:0] readWord(input logic [7:0] v, input logic rdy);
        return {24'h0, v[7], rdy, v[5:0]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            miscompares++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 20);
        rd = prdata; rdHv = prdataHv; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic complete_run;
        if (miscompares == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin miscompares++; complete_run; end
    end
    // ==========================================
    // main sequence
    initial begin
        void'($urandom(70));
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        xfer(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        // first four sweep every gain code in both fields, the rest are random
        for (int i = 0; i < 24; i++) begin
            d = (i < 4) ? 8'(i * 8'h55) : 8'($urandom);
            refSettled <= (i < 4) ? 1'b1 : 1'($urandom);
            xfer(1'b1, 12'h000, {24'($urandom), d});
            @(posedge sys_clk);
            chk({24'h0, referenceEnable, 1'b0, tempIndicatorEnable, tempRangeSelect,
                cmpDacGainSelect, adcGainSelect}, {24'h0, d[7], 1'b0, d[5:0]});
            chk({26'h0, cmpDacGain, adcGain}, {26'h0, gainOneHot(d[3:2]), gainOneHot(d[1:0])});
            xfer(1'b0, 12'h000, 32'hffffffff);
            chk(rd, readWord(d, d[7] & refSettled));
            chk(rdHv, readWord(d, 1'b1));
        end
        // unmapped address is refused and leaves the register alone
        xfer(1'b1, 12'h004, 32'h000000ff);
        chk({31'h0, err}, 32'h1);
        @(posedge sys_clk);
        xfer(1'b0, 12'h000, 32'h0);
        chk(rd, readWord(d, d[7] & refSettled));
        // a write while the clock enable is low is dropped
        clkEn <= 1'b0;
        xfer(1'b1, 12'h000, {24'h0, ~d});
        clkEn <= 1'b1;
        @(posedge sys_clk);
        chk({31'h0, referenceEnable}, {31'h0, d[7]});
        xfer(1'b0, 12'h000, 32'h0);
        chk(rd, readWord(d, d[7] & refSettled));
        chk({31'h0, err}, 32'h0);
        complete_run;
    end
endmodule
`default_nettype wire
